// >>> src/pci_id_default_hooks.sv
// Hook register bank with APB slave, PCI-reset latch and external access gate
//
// Overview of operation
// - Identity program register, 32 bits, feeds vendor and part code mirror defaults.
// - Class program register, 32 bits, feeds class and revision mirror defaults.
// - Subsystem program register, reset zero, feeds subsystem mirror defaults.
// - Latency grant program: low 16 bits writable, upper 16 read zero.
// - External accesses held off until setup complete flag is one.
// - Setup complete bit 0: 0 blocks, 1 allows; upper bits read zero.
// - Setup complete flag resets to zero, blocking external accesses.
// - Each PCI reset copies the four program registers into their mirror fields; setup complete has no mirror.
// - Software may overwrite hook registers before the next PCI reset.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module pci_id_default_hooks (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // PCI side
    input  wire logic        pci_reset,
    input  wire logic        ext_request,
    output var  logic        ext_allow,
    output var  logic        ext_retry,
    output var  logic [31:0] identity_mirror,
    output var  logic [31:0] class_mirror,
    output var  logic [31:0] subsystem_mirror,
    output var  logic [15:0] latency_grant_mirror
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    hook_pkg::defaults_type prog_d;
    hook_pkg::defaults_type prog_q;
    hook_pkg::defaults_type mirror_w;
    logic                   done_d;
    logic                   done_q;
    logic [31:0]            rdata_d;
    logic [31:0]            rdata_q;
    logic                   err_d;
    logic                   err_q;
    logic                   ready_d;
    logic                   ready_q;
    logic                   setup_w;
    logic                   wr_w;
    logic                   hit_w;

    // Setup phase captures the answer; access phase completes with it
    assign setup_w = psel && !penable;
    assign wr_w    = psel && penable && ready_q && pwrite && !err_q;

    always_comb begin
        unique case (paddr)
            hook_pkg::ID_PROG_OFFSET,
            hook_pkg::CLASS_PROG_OFFSET,
            hook_pkg::SUBSYS_PROG_OFFSET,
            hook_pkg::LATGNT_PROG_OFFSET,
            hook_pkg::SETUP_DONE_OFFSET: hit_w = 1'b1;
            default:                     hit_w = 1'b0;
        endcase
    end

    always_comb begin
        prog_d  = prog_q;
        done_d  = done_q;
        rdata_d = rdata_q;
        // Error stands only in the access cycle, alongside pready
        err_d   = 1'b0;
        ready_d = 1'b0;
        if (setup_w) begin
            ready_d = 1'b1;
            err_d   = !hit_w;
            rdata_d = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    hook_pkg::ID_PROG_OFFSET:     rdata_d = prog_q.identity;
                    hook_pkg::CLASS_PROG_OFFSET:  rdata_d = prog_q.class_rev;
                    hook_pkg::SUBSYS_PROG_OFFSET: rdata_d = prog_q.subsystem;
                    hook_pkg::LATGNT_PROG_OFFSET: rdata_d = {16'h0000, prog_q.latency_grant};
                    hook_pkg::SETUP_DONE_OFFSET:  rdata_d = {31'h0000_0000, done_q};
                    default:                      rdata_d = 32'h0000_0000;
                endcase
            end
        end
        // Writes land any time; mirrors only follow at the PCI reset
        if (wr_w) begin
            unique case (paddr)
                hook_pkg::ID_PROG_OFFSET:     prog_d.identity = pwdata;
                hook_pkg::CLASS_PROG_OFFSET:  prog_d.class_rev = pwdata;
                hook_pkg::SUBSYS_PROG_OFFSET: prog_d.subsystem = pwdata;
                hook_pkg::LATGNT_PROG_OFFSET: prog_d.latency_grant = pwdata[15:0];
                hook_pkg::SETUP_DONE_OFFSET:  done_d = pwdata[hook_pkg::SETUP_DONE_BIT];
                default:                      done_d = done_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_q  <= '{hook_pkg::ID_PROG_RESET, hook_pkg::CLASS_PROG_RESET,
                         hook_pkg::SUBSYS_PROG_RESET, hook_pkg::LATGNT_PROG_RESET};
            done_q  <= hook_pkg::SETUP_DONE_RESET;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            prog_q  <= prog_d;
            done_q  <= done_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
            ready_q <= ready_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    hook_mirror_latch u_latch (
        .clk            (clk),
        .rst            (rst),
        .pci_reset      (pci_reset),
        .program_values (prog_q),
        .mirror_values  (mirror_w)
    );

    access_gate u_gate (
        .clk         (clk),
        .rst         (rst),
        .setup_done  (done_q),
        .ext_request (ext_request),
        .ext_allow   (ext_allow),
        .ext_retry   (ext_retry)
    );

    assign identity_mirror      = mirror_w.identity;
    assign class_mirror         = mirror_w.class_rev;
    assign subsystem_mirror     = mirror_w.subsystem;
    assign latency_grant_mirror = mirror_w.latency_grant;

    // ****************************************************************
    // Reset and write checks
    // ****************************************************************
    done_reset_a: assert property (@(posedge clk)
        rst
        |=> (done_q == 1'b0 && prog_q.subsystem == 32'h0000_0000))
        else $error("Reset values wrong");

    id_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_w && paddr == hook_pkg::ID_PROG_OFFSET
        |=> prog_q.identity == $past(pwdata))
        else $error("Identity program write lost");

    class_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_w && paddr == hook_pkg::CLASS_PROG_OFFSET
        |=> prog_q.class_rev == $past(pwdata))
        else $error("Class program write lost");

    subsys_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_w && paddr == hook_pkg::SUBSYS_PROG_OFFSET
        |=> prog_q.subsystem == $past(pwdata))
        else $error("Subsystem program write lost");

    prog_overwrite_a: assert property (@(posedge clk) disable iff (rst)
        wr_w && paddr == hook_pkg::LATGNT_PROG_OFFSET
        |=> prog_q.latency_grant == $past(pwdata[15:0]))
        else $error("Latency grant program write lost");

    done_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_w && paddr == hook_pkg::SETUP_DONE_OFFSET
        |=> done_q == $past(pwdata[hook_pkg::SETUP_DONE_BIT]))
        else $error("Setup complete write lost");

    done_hold_a: assert property (@(posedge clk) disable iff (rst)
        !(wr_w && paddr == hook_pkg::SETUP_DONE_OFFSET)
        |=> $stable(done_q))
        else $error("Setup complete changed without a write");

    // ****************************************************************
    // Read checks
    // ****************************************************************
    id_read_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::ID_PROG_OFFSET
        |=> prdata == $past(prog_q.identity))
        else $error("Identity program read wrong");

    class_read_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::CLASS_PROG_OFFSET
        |=> prdata == $past(prog_q.class_rev))
        else $error("Class program read wrong");

    subsys_read_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::SUBSYS_PROG_OFFSET
        |=> prdata == $past(prog_q.subsystem))
        else $error("Subsystem program read wrong");

    latgnt_read_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::LATGNT_PROG_OFFSET
        |=> prdata[31:16] == 16'h0000)
        else $error("Latency grant upper bits not zero");

    latgnt_low_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::LATGNT_PROG_OFFSET
        |=> prdata[15:0] == $past(prog_q.latency_grant))
        else $error("Latency grant field read wrong");

    done_read_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !pwrite && paddr == hook_pkg::SETUP_DONE_OFFSET
        |=> prdata == {31'h0000_0000, $past(done_q)})
        else $error("Setup complete read wrong");

    // ****************************************************************
    // Bus response checks
    // ****************************************************************
    ready_answer_a: assert property (@(posedge clk) disable iff (rst)
        setup_w
        |=> pready)
        else $error("No ready in the access cycle");

    ready_single_a: assert property (@(posedge clk) disable iff (rst)
        pready
        |=> !pready)
        else $error("Ready stood longer than one cycle");

    unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && !hit_w
        |=> (pready && pslverr))
        else $error("Unmapped access not flagged");

    mapped_ok_a: assert property (@(posedge clk) disable iff (rst)
        setup_w && hit_w
        |=> !pslverr)
        else $error("Mapped access flagged as error");

    unmapped_nowrite_a: assert property (@(posedge clk) disable iff (rst)
        pready && pslverr
        |=> ($stable(prog_q) && $stable(done_q)))
        else $error("Unmapped write changed a register");

    // ****************************************************************
    // Mirror and gate checks
    // ****************************************************************
    mirror_latch_a: assert property (@(posedge clk) disable iff (rst)
        pci_reset
        |=> identity_mirror == $past(prog_q.identity))
        else $error("Identity mirror not latched");

    class_latch_a: assert property (@(posedge clk) disable iff (rst)
        pci_reset
        |=> class_mirror == $past(prog_q.class_rev))
        else $error("Class mirror not latched");

    subsys_latch_a: assert property (@(posedge clk) disable iff (rst)
        pci_reset
        |=> subsystem_mirror == $past(prog_q.subsystem))
        else $error("Subsystem mirror not latched");

    latgnt_latch_a: assert property (@(posedge clk) disable iff (rst)
        pci_reset
        |=> latency_grant_mirror == $past(prog_q.latency_grant))
        else $error("Latency grant mirror not latched");

    id_hold_a: assert property (@(posedge clk) disable iff (rst)
        !pci_reset
        |=> $stable(identity_mirror))
        else $error("Identity mirror moved without PCI reset");

    class_hold_a: assert property (@(posedge clk) disable iff (rst)
        !pci_reset
        |=> $stable(class_mirror))
        else $error("Class mirror moved without PCI reset");

    mirror_stable_a: assert property (@(posedge clk) disable iff (rst)
        !pci_reset
        |=> $stable(subsystem_mirror))
        else $error("Mirror moved without PCI reset");

    latgnt_hold_a: assert property (@(posedge clk) disable iff (rst)
        !pci_reset
        |=> $stable(latency_grant_mirror))
        else $error("Latency grant mirror moved without PCI reset");

    gate_follow_a: assert property (@(posedge clk) disable iff (rst)
        !done_q
        |=> !ext_allow)
        else $error("External access allowed before setup complete");

    gate_open_a: assert property (@(posedge clk) disable iff (rst)
        done_q
        |=> ext_allow)
        else $error("External access not allowed after setup complete");

    gate_retry_a: assert property (@(posedge clk) disable iff (rst)
        ext_request && !done_q
        |=> ext_retry)
        else $error("Blocked external access not retried");

    gate_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !ext_request || done_q
        |=> !ext_retry)
        else $error("Retry raised without a blocked access");
endmodule
`default_nettype wire

// >>> pkg/hook_pkg.sv
// Package of offsets, reset values and carrier types for the hook register bank
package hook_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ID_PROG_OFFSET    = 12'h394;
    localparam logic [11:0] CLASS_PROG_OFFSET = 12'h39C;
    localparam logic [11:0] SUBSYS_PROG_OFFSET = 12'h3A0;
    localparam logic [11:0] LATGNT_PROG_OFFSET = 12'h3A4;
    localparam logic [11:0] SETUP_DONE_OFFSET  = 12'h3AC;

    // ****************************************************************
    // Reset values; identity defaults are arbitrary neutral values
    // ****************************************************************
    localparam logic [31:0] ID_PROG_RESET     = 32'h0000_0001;
    localparam logic [31:0] CLASS_PROG_RESET  = 32'h0000_0002;
    localparam logic [31:0] SUBSYS_PROG_RESET = 32'h0000_0000;
    localparam logic [15:0] LATGNT_PROG_RESET = 16'h0000;
    localparam logic        SETUP_DONE_RESET  = 1'b0;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int LATGNT_WIDTH   = 16;
    localparam int SETUP_DONE_BIT = 0;
    localparam int DEFAULT_COUNT  = 4;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [31:0] identity;
        logic [31:0] class_rev;
        logic [31:0] subsystem;
        logic [15:0] latency_grant;
    } defaults_type;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } bus_req_type;

endpackage

// >>> src/hook_mirror_latch.sv
// Mirror latch that copies hook defaults into bus-visible fields on PCI reset
`timescale 1ns/10ps
`default_nettype none
module hook_mirror_latch (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Latch event and source defaults
    input  wire logic                 pci_reset,
    input  wire hook_pkg::defaults_type program_values,
    // Mirror fields
    output var  hook_pkg::defaults_type mirror_values
);
    hook_pkg::defaults_type mirror_d;
    hook_pkg::defaults_type mirror_q;

    always_comb begin
        mirror_d = mirror_q;
        // Only a PCI reset moves the mirrors; later program writes wait
        if (pci_reset) begin
            mirror_d = program_values;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mirror_q <= '{hook_pkg::ID_PROG_RESET, hook_pkg::CLASS_PROG_RESET,
                          hook_pkg::SUBSYS_PROG_RESET, hook_pkg::LATGNT_PROG_RESET};
        end else begin
            mirror_q <= mirror_d;
        end
    end

    assign mirror_values = mirror_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    mirror_copies_a: assert property (@(posedge clk) disable iff (rst)
        pci_reset |=> mirror_q == $past(program_values))
        else $error("Mirror did not take program values on PCI reset");

    mirror_holds_a: assert property (@(posedge clk) disable iff (rst)
        !pci_reset |=> mirror_q == $past(mirror_q))
        else $error("Mirror changed without PCI reset");
endmodule
`default_nettype wire

// >>> src/access_gate.sv
// Gate that holds off external host accesses until setup is complete
`timescale 1ns/10ps
`default_nettype none
module access_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic setup_done,
    input  wire logic ext_request,
    // Result
    output var  logic ext_allow,
    output var  logic ext_retry
);
    logic allow_d;
    logic allow_q;
    logic retry_d;
    logic retry_q;

    always_comb begin
        allow_d = setup_done;
        retry_d = ext_request && !setup_done;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            allow_q <= 1'b0;
            retry_q <= 1'b0;
        end else begin
            allow_q <= allow_d;
            retry_q <= retry_d;
        end
    end

    assign ext_allow = allow_q;
    assign ext_retry = retry_q;

    blocked_retry_a: assert property (@(posedge clk) disable iff (rst)
        (ext_request && !setup_done) |=> (ext_retry && !ext_allow))
        else $error("External access not held off before setup done");
endmodule
`default_nettype wire

// >>> sim/pci_host_model.sv
// Behavioural external PCI host: raises the latch event and access attempts
`timescale 1ns/10ps
`default_nettype none
module pci_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Commands from the bench
    input  wire logic latch_cmd,
    input  wire logic access_cmd,
    // Toward the block
    output var  logic pci_reset,
    output var  logic ext_request
);
    logic pci_reset_d;
    logic ext_request_d;
    // Host keeps retrying as long as it is told to; nothing is driven in reset
    always_comb begin
        pci_reset_d   = latch_cmd & ~rst;
        ext_request_d = access_cmd & ~rst;
    end
    always_ff @(posedge clk) begin
        pci_reset   <= pci_reset_d;
        ext_request <= ext_request_d;
    end
endmodule
`default_nettype wire

// >>> sim/pci_id_default_hooks_test.sv
// Self-checking bench for the hook register bank
`timescale 1ns/10ps
`default_nettype none
module pci_id_default_hooks_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, idm, clm, sbm;
    logic pready, pslverr, pci_reset, ext_request, ext_allow, ext_retry;
    logic latch_cmd = 1'b0, access_cmd = 1'b0;
    logic [15:0] lgm;
    int err_total = 0, comparisons = 0, cycles = 0;
    // ****************************************************************
    // Harness
    // ****************************************************************
    pci_host_model i_host (.clk(clk), .rst(rst), .latch_cmd(latch_cmd), .access_cmd(access_cmd),
        .pci_reset(pci_reset), .ext_request(ext_request));
    pci_id_default_hooks i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pci_reset(pci_reset), .ext_request(ext_request), .ext_allow(ext_allow), .ext_retry(ext_retry),
        .identity_mirror(idm), .class_mirror(clm), .subsystem_mirror(sbm), .latency_grant_mirror(lgm));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Generous ceiling: the whole sequence needs well under 300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
            err_total = err_total + 1;
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle so psel never toggles twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'h0000_0000);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk(32'(e), 32'h0000_0000);
    endtask
    task automatic mirrors(input hook_pkg::defaults_type x);
        repeat (3) @(posedge clk);
        #1;
        chk(idm, x.identity);
        chk(clm, x.class_rev);
        chk(sbm, x.subsystem);
        chk(32'(lgm), 32'(x.latency_grant));
        @(posedge clk);
    endtask
    task automatic latch();
        latch_cmd <= 1'b1;
        @(posedge clk);
        latch_cmd <= 1'b0;
    endtask
    task automatic access(input logic exp_retry, input logic exp_allow);
        access_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(32'(ext_retry), 32'(exp_retry));
        chk(32'(ext_allow), 32'(exp_allow));
        @(posedge clk);
        access_cmd <= 1'b0;
        @(posedge clk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_resets();
        rd(hook_pkg::ID_PROG_OFFSET, hook_pkg::ID_PROG_RESET);
        rd(hook_pkg::CLASS_PROG_OFFSET, hook_pkg::CLASS_PROG_RESET);
        rd(hook_pkg::SUBSYS_PROG_OFFSET, 32'h0000_0000);
        rd(hook_pkg::LATGNT_PROG_OFFSET, 32'(hook_pkg::LATGNT_PROG_RESET));
        rd(hook_pkg::SETUP_DONE_OFFSET, 32'h0000_0000);
        mirrors({hook_pkg::ID_PROG_RESET, hook_pkg::CLASS_PROG_RESET, 32'h0000_0000, 16'h0000});
        access(1'b1, 1'b0);
        $display("test resets done");
    endtask
    task automatic test_program();
        wr(hook_pkg::ID_PROG_OFFSET, 32'hA5A5_0F0F);
        wr(hook_pkg::CLASS_PROG_OFFSET, 32'h5A5A_F0F0);
        wr(hook_pkg::SUBSYS_PROG_OFFSET, 32'hFFFF_FFFF);
        wr(hook_pkg::LATGNT_PROG_OFFSET, 32'hFFFF_1234);
        rd(hook_pkg::ID_PROG_OFFSET, 32'hA5A5_0F0F);
        rd(hook_pkg::CLASS_PROG_OFFSET, 32'h5A5A_F0F0);
        rd(hook_pkg::SUBSYS_PROG_OFFSET, 32'hFFFF_FFFF);
        rd(hook_pkg::LATGNT_PROG_OFFSET, 32'h0000_1234);
        mirrors({hook_pkg::ID_PROG_RESET, hook_pkg::CLASS_PROG_RESET, 32'h0000_0000, 16'h0000});
        latch();
        mirrors({32'hA5A5_0F0F, 32'h5A5A_F0F0, 32'hFFFF_FFFF, 16'h1234});
        wr(hook_pkg::ID_PROG_OFFSET, 32'h1234_5678);
        mirrors({32'hA5A5_0F0F, 32'h5A5A_F0F0, 32'hFFFF_FFFF, 16'h1234});
        latch();
        mirrors({32'h1234_5678, 32'h5A5A_F0F0, 32'hFFFF_FFFF, 16'h1234});
        $display("test program done");
    endtask
    task automatic test_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b1, 12'h3A8, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h0000_0001);
        apb(1'b0, 12'h3A8, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        $display("test unmapped done");
    endtask
    task automatic test_gate();
        wr(hook_pkg::SETUP_DONE_OFFSET, 32'hFFFF_FFFF);
        rd(hook_pkg::SETUP_DONE_OFFSET, 32'h0000_0001);
        access(1'b0, 1'b1);
        wr(hook_pkg::SETUP_DONE_OFFSET, 32'h0000_0000);
        rd(hook_pkg::SETUP_DONE_OFFSET, 32'h0000_0000);
        access(1'b1, 1'b0);
        $display("test gate done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_resets();
        test_program();
        test_unmapped();
        test_gate();
        close_out();
    end
endmodule
`default_nettype wire
